//--- pkg/qei_defines.vh
// Register map, field positions, reset values and timing figures for the
// quadrature encoder integration block.
// Assumes a 32-bit APB master and one peripheral clock for all logic.
//
// Functional notes
// - Setting bit 9 of the clock domain disable register stops the encoder clock, clearing it lets it run.
// - After reset the encoder clock runs without any software action.
// - Each encoder module flags a phase error on an illegal transition of its phase A and phase B inputs.
// - The phase errors of both encoder modules feed a selection multiplexer that forwards one of them.
// - The multiplexer output is inverted and routed to the high-end timer input.
// - Phase A takes the synchronized path when select bit 0 is set, the filtered path when bit 0 is clear and bit 1 set.
// - Phase B takes the synchronized path when select bit 8 is set, the filtered path when bit 8 is clear and bit 9 set.
// - Index takes the synchronized path when select bit 16 is set, the filtered path when bit 16 is clear and bit 17 set.
// - Strobe takes the synchronized path when select bit 24 is set, the filtered path when bit 24 is clear and bit 25 set.
// - The position counter moves no later than four clocks after the input edge, except on the filtered path with a filter width above 0.
// - The position compare sync output answers within six clocks of the input edge, except on the filtered path with a filter width above 2.

`ifndef QEI_DEFINES_VH
`define QEI_DEFINES_VH

// Byte offsets of the registers.
`define QEI_ADDR_CLK_DIS     12'h000
`define QEI_ADDR_PATH_SEL    12'h004
`define QEI_ADDR_CTRL        12'h008
`define QEI_ADDR_INT_STAT    12'h00c
`define QEI_ADDR_INT_MASK    12'h010
`define QEI_ADDR_POS0        12'h014
`define QEI_ADDR_POS1        12'h018
`define QEI_ADDR_CMP0        12'h01c
`define QEI_ADDR_CMP1        12'h020
`define QEI_ADDR_PIN_LEVEL   12'h024

// Field positions.
`define QEI_CLK_DIS_BIT      9
`define QEI_CTRL_ERR_SEL     0
`define QEI_CTRL_FILT_LO     4
`define QEI_CTRL_FILT_HI     7
`define QEI_SEL_SYNC_OFS     0
`define QEI_SEL_FILT_OFS     1
`define QEI_SEL_STRIDE       8

// Reset values.
`define QEI_RST_CLK_DIS      32'h00000000
`define QEI_RST_PATH_SEL     32'h00000000
`define QEI_RST_CTRL         32'h00000000
`define QEI_RST_CMP          32'h00000000

// Timing: clock period and worst-case latencies in clocks.
`define QEI_CLK_PERIOD_NS    40
`define QEI_CNT_LAT_CLKS     4
`define QEI_CMP_LAT_CLKS     6
`define QEI_MIN_HOLD_CLKS    2

`endif

//--- rtl/qei_input_path.v
// One encoder input: two-flop synchronizer, optional glitch filter and the
// path selection between them.
// Assumes the pin is asynchronous to clk_sys and the width is static.
`timescale 1ns/1ns

module qei_input_path (
    input  wire       clk_sys,
    input  wire       reset_n,
    input  wire       pin,
    input  wire       sel_sync,
    input  wire       sel_filt,
    input  wire [3:0] filt_width,
    output wire       path_out
);

    reg       sync_a;
    reg       sync_b;
    reg       filt_q;
    reg [3:0] filt_cnt;

    // Two flops; only sync_b is looked at by any logic.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end else begin
            sync_a <= pin;
            sync_b <= sync_a;
        end
    end

    // The filter passes a new level only after it stood filt_width extra
    // clocks, so the encoder must hold levels that much longer.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            filt_q   <= 1'b0;
            filt_cnt <= 4'h0;
        end else if (sync_b == filt_q) begin
            filt_cnt <= 4'h0;
        end else if (filt_cnt >= filt_width) begin
            filt_q   <= sync_b;
            filt_cnt <= 4'h0;
        end else begin
            filt_cnt <= filt_cnt + 4'h1;
        end
    end

    // Sync bit wins; the filter is used only when its own bit alone is set.
    // An all-clear selection falls back to the synchronized path.
    assign path_out = sel_sync ? sync_b :
                      (sel_filt ? filt_q : sync_b);

endmodule

//--- rtl/qei_integration.v
// Quadrature encoder integration: APB registers, encoder clock enable,
// input path selection, a small position decoder per encoder and the
// inverted phase-error route to the high-end timer.
// Assumes an APB master on clk_sys and asynchronous encoder pins.
`timescale 1ns/1ns
`include "qei_defines.vh"

module qei_integration (
    input  wire        clk_sys,
    input  wire        reset_n,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    input  wire [1:0]  quad_phase_a_in,
    input  wire [1:0]  quad_phase_b_in,
    input  wire [1:0]  index_in,
    input  wire [1:0]  strobe_in,
    output reg  [1:0]  phase_error_out,
    output reg  [1:0]  cmp_sync_out,
    output reg         high_end_timer_err_n,
    output reg         irq
);

    reg  [31:0] clock_domain_disable_reg;
    reg  [31:0] input_path_select_reg;
    reg  [31:0] ctrl_reg;
    reg  [3:0]  int_stat;
    reg  [3:0]  int_mask;
    reg  [31:0] pos [0:1];
    reg  [31:0] cmp [0:1];
    reg  [1:0]  prev_ab [0:1];
    reg  [1:0]  prev_idx;
    wire [7:0]  path;
    wire [3:0]  evt;
    wire        enc_run;
    wire        acc;
    wire        wr;
    reg         map_hit;
    reg  [31:0] next_rdata;

    // Step of a quadrature pair: 01 count up, 10 count down, 11 illegal.
    function [1:0] quad_step;
        input [1:0] was;
        input [1:0] now;
        begin
            case ({was, now})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: quad_step = 2'b01;
                4'b0010, 4'b1011, 4'b1101, 4'b0100: quad_step = 2'b10;
                4'b0011, 4'b1100, 4'b0110, 4'b1001: quad_step = 2'b11;
                default:                            quad_step = 2'b00;
            endcase
        end
    endfunction

    // Address decode shared by read and write.
    function is_mapped;
        input [11:0] a;
        begin
            case (a)
                `QEI_ADDR_CLK_DIS, `QEI_ADDR_PATH_SEL, `QEI_ADDR_CTRL,
                `QEI_ADDR_INT_STAT, `QEI_ADDR_INT_MASK, `QEI_ADDR_POS0,
                `QEI_ADDR_POS1, `QEI_ADDR_CMP0, `QEI_ADDR_CMP1,
                `QEI_ADDR_PIN_LEVEL: is_mapped = 1'b1;
                default:             is_mapped = 1'b0;
            endcase
        end
    endfunction

    // The encoder domain is stopped by an enable rather than a gated clock,
    // which keeps one clock tree; the bus side keeps running regardless.
    assign enc_run = ~clock_domain_disable_reg[`QEI_CLK_DIS_BIT];

    // APB access phase; the write lands in the cycle pready is seen high.
    assign acc = psel & penable;
    assign wr  = acc & pready & pwrite;

    // Eight input paths: index e*4+k holds input kind k of encoder e,
    // kind order phase A, phase B, index, strobe.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_path
            wire pin_w;
            assign pin_w = (gi % 4 == 0) ? quad_phase_a_in[gi / 4] :
                           (gi % 4 == 1) ? quad_phase_b_in[gi / 4] :
                           (gi % 4 == 2) ? index_in[gi / 4] :
                                           strobe_in[gi / 4];
            qei_input_path u_path (
                .clk_sys    (clk_sys),
                .reset_n    (reset_n),
                .pin        (pin_w),
                .sel_sync   (input_path_select_reg[(gi % 4) *
                             `QEI_SEL_STRIDE + `QEI_SEL_SYNC_OFS]),
                .sel_filt   (input_path_select_reg[(gi % 4) *
                             `QEI_SEL_STRIDE + `QEI_SEL_FILT_OFS]),
                .filt_width (ctrl_reg[`QEI_CTRL_FILT_HI:`QEI_CTRL_FILT_LO]),
                .path_out   (path[gi])
            );
        end
    endgenerate

    // Per-encoder decoder: counts, flags illegal steps, clears on index
    // rising and pulses the compare sync when the new count matches.
    genvar ge;
    generate
        for (ge = 0; ge < 2; ge = ge + 1) begin : g_enc
            wire [1:0] ab_now;
            wire [1:0] step;
            wire       idx_rise;
            reg  [31:0] next_pos;
            assign ab_now   = {path[ge * 4], path[ge * 4 + 1]};
            assign step     = quad_step(prev_ab[ge], ab_now);
            assign idx_rise = path[ge * 4 + 2] & ~prev_idx[ge];

            // Next position, computed once for counter and comparator.
            always @* begin
                next_pos = pos[ge];
                if (idx_rise) begin
                    next_pos = 32'h00000000;
                end else if (step == 2'b01) begin
                    next_pos = pos[ge] + 32'h00000001;
                end else if (step == 2'b10) begin
                    next_pos = pos[ge] - 32'h00000001;
                end
            end

            // Counter moves the clock after the synchronized edge, three
            // clocks after the pin on the plain path.
            always @(posedge clk_sys or negedge reset_n) begin
                if (!reset_n) begin
                    prev_ab[ge]         <= 2'b00;
                    prev_idx[ge]        <= 1'b0;
                    pos[ge]             <= 32'h00000000;
                    phase_error_out[ge] <= 1'b0;
                    cmp_sync_out[ge]    <= 1'b0;
                end else if (enc_run) begin
                    prev_ab[ge]         <= ab_now;
                    prev_idx[ge]        <= path[ge * 4 + 2];
                    pos[ge]             <= next_pos;
                    phase_error_out[ge] <= (step == 2'b11);
                    cmp_sync_out[ge]    <= (step != 2'b00) &&
                                           (step != 2'b11) &&
                                           (next_pos == cmp[ge]);
                end else begin
                    phase_error_out[ge] <= 1'b0;
                    cmp_sync_out[ge]    <= 1'b0;
                end
            end
            assign evt[ge]     = phase_error_out[ge];
            assign evt[ge + 2] = cmp_sync_out[ge];
        end
    endgenerate

    // Selected error is inverted toward the timer, so idle reads high.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            high_end_timer_err_n <= 1'b1;
        end else begin
            high_end_timer_err_n <= ~(ctrl_reg[`QEI_CTRL_ERR_SEL] ?
                phase_error_out[1] : phase_error_out[0]);
        end
    end

    // Software registers. Reset leaves the encoder clock running.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clock_domain_disable_reg <= `QEI_RST_CLK_DIS;
            input_path_select_reg    <= `QEI_RST_PATH_SEL;
            ctrl_reg                 <= `QEI_RST_CTRL;
            int_mask                 <= 4'h0;
            cmp[0]                   <= `QEI_RST_CMP;
            cmp[1]                   <= `QEI_RST_CMP;
        end else if (wr) begin
            case (paddr)
                `QEI_ADDR_CLK_DIS:  clock_domain_disable_reg <= pwdata;
                `QEI_ADDR_PATH_SEL: input_path_select_reg    <= pwdata;
                `QEI_ADDR_CTRL:     ctrl_reg                 <= pwdata;
                `QEI_ADDR_INT_MASK: int_mask                 <= pwdata[3:0];
                `QEI_ADDR_CMP0:     cmp[0]                   <= pwdata;
                `QEI_ADDR_CMP1:     cmp[1]                   <= pwdata;
                default:            ctrl_reg                 <= ctrl_reg;
            endcase
        end
    end

    // Sticky events; a new event wins over a write-one clear.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            int_stat <= 4'h0;
        end else if (wr && paddr == `QEI_ADDR_INT_STAT) begin
            int_stat <= (int_stat & ~pwdata[3:0]) | evt;
        end else begin
            int_stat <= int_stat | evt;
        end
    end

    // One level interrupt from the unmasked sticky bits.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(int_stat & int_mask);
        end
    end

    // Read mux; unmapped addresses read zero.
    always @* begin
        map_hit    = is_mapped(paddr);
        next_rdata = 32'h00000000;
        case (paddr)
            `QEI_ADDR_CLK_DIS:   next_rdata = clock_domain_disable_reg;
            `QEI_ADDR_PATH_SEL:  next_rdata = input_path_select_reg;
            `QEI_ADDR_CTRL:      next_rdata = ctrl_reg;
            `QEI_ADDR_INT_STAT:  next_rdata = {28'h0000000, int_stat};
            `QEI_ADDR_INT_MASK:  next_rdata = {28'h0000000, int_mask};
            `QEI_ADDR_POS0:      next_rdata = pos[0];
            `QEI_ADDR_POS1:      next_rdata = pos[1];
            `QEI_ADDR_CMP0:      next_rdata = cmp[0];
            `QEI_ADDR_CMP1:      next_rdata = cmp[1];
            `QEI_ADDR_PIN_LEVEL: next_rdata = {24'h000000, path};
            default:             next_rdata = 32'h00000000;
        endcase
    end

    // One wait state: pready rises in the second access cycle, and the
    // response is held valid with it for that single cycle.
    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else if (acc && !pready) begin
            pready  <= 1'b1;
            pslverr <= ~map_hit;
            prdata  <= pwrite ? 32'h00000000 : next_rdata;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end
    end

endmodule

//--- verif/qei_integration_chk.sv
// Port-level assertions for the encoder integration block.
// Assumes one clock domain, clk_sys, with reset_n active low.
`timescale 1ns/1ns
module qei_integration_chk (
    input wire        clk_sys,
    input wire        reset_n,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [1:0]  quad_phase_a_in,
    input wire [1:0]  quad_phase_b_in,
    input wire [1:0]  index_in,
    input wire [1:0]  strobe_in,
    input wire [1:0]  phase_error_out,
    input wire [1:0]  cmp_sync_out,
    input wire        high_end_timer_err_n,
    input wire        irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    // The slave answers after exactly one wait state.
    property p_ready_wait;
        $rose(penable) && psel |=> pready;
    endproperty
    a_ready_wait: assert property (p_ready_wait)
        else $error("pready not one cycle after access start");
    // A second pready would complete a transfer that was never started.
    property p_ready_once;
        pready |=> !pready;
    endproperty
    a_ready_once: assert property (p_ready_once)
        else $error("pready longer than one cycle");
    property p_slverr_ready;
        pslverr |-> pready;
    endproperty
    a_slverr_ready: assert property (p_slverr_ready)
        else $error("pslverr outside the pready cycle");
    property p_rdata_idle;
        !pready |-> prdata == 32'h00000000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("prdata not zero outside pready");
    property p_err_pulse;
        phase_error_out[0] |=> !phase_error_out[0];
    endproperty
    a_err_pulse: assert property (p_err_pulse)
        else $error("phase error longer than one cycle");
    // The timer input may only fall after an error pulse one cycle before.
    property p_tmr_cause;
        !high_end_timer_err_n |-> $past(|phase_error_out);
    endproperty
    a_tmr_cause: assert property (p_tmr_cause)
        else $error("timer error input low without an error pulse");
    property p_tmr_pulse;
        $fell(high_end_timer_err_n) |=> high_end_timer_err_n;
    endproperty
    a_tmr_pulse: assert property (p_tmr_pulse)
        else $error("timer error input low too long");
    property p_cmp_pulse;
        cmp_sync_out[0] |=> !cmp_sync_out[0];
    endproperty
    a_cmp_pulse: assert property (p_cmp_pulse)
        else $error("compare sync longer than one cycle");
endmodule

//--- verif/qei_enc_model.sv
// Behavioural incremental encoder driving the pins of both encoders.
// Assumes its tasks are called from a process synchronous to clk_sys.
`timescale 1ns/1ns
module qei_enc_model #(
    parameter HOLD_CLKS = 4
) (
    input  wire       clk_sys,
    output reg  [1:0] quad_a,
    output reg  [1:0] quad_b,
    output reg  [1:0] idx,
    output reg  [1:0] stb
);
    integer n;
    initial begin
        quad_a = 2'h0;
        quad_b = 2'h0;
        idx = 2'h0;
        stb = 2'h0;
    end
    // Levels stand longer than the two-flop minimum, so none is lost.
    task hold;
        for (n = 0; n < HOLD_CLKS; n = n + 1)
            @(posedge clk_sys);
    endtask
    // One legal step; only one phase moves at a time.
    task step(input integer e, input integer up);
        reg [1:0] ab;
        begin
            ab = {quad_a[e], quad_b[e]};
            @(posedge clk_sys);
            quad_a[e] <= up ? ab[0] : ~ab[0];
            quad_b[e] <= up ? ~ab[1] : ab[1];
            hold;
        end
    endtask
    // Both phases move together, as only a faulty encoder does.
    task bad(input integer e);
        begin
            @(posedge clk_sys);
            quad_a[e] <= ~quad_a[e];
            quad_b[e] <= ~quad_b[e];
            hold;
        end
    endtask
    // Input k (0 A, 1 B, 2 index, 3 strobe) of both encoders.
    task lvl(input integer k, input v);
        begin
            @(posedge clk_sys);
            case (k)
                0: quad_a <= {2{v}};
                1: quad_b <= {2{v}};
                2: idx <= {2{v}};
                default: stb <= {2{v}};
            endcase
            hold;
        end
    endtask
endmodule

//--- verif/qei_integration_tb.sv
// Self-checking bench for the encoder integration block.
// Assumes the encoder model drives the pins and APB runs on clk_sys.
`timescale 1ns/1ns
`include "qei_defines.vh"
module qei_integration_tb;
    reg         clk_sys = 1'b0;
    reg         reset_n = 1'b0;
    reg         psel = 1'b0;
    reg         penable = 1'b0;
    reg         pwrite = 1'b0;
    reg  [11:0] paddr = 12'h000;
    reg  [31:0] pwdata = 32'h00000000;
    wire [31:0] prdata;
    wire        pready;
    wire        pslverr;
    wire [1:0]  qa, qb, qi, qs, perr, csync;
    wire        tmr_n;
    wire        irq;
    integer     tmr_lows = 0;
    integer     cmp_hits = 0;
    integer     base;
    reg  [31:0] rd;
    reg         rerr;
    integer     err_count = 0;
    integer     n_checks = 0;
    integer     cyc = 0;
    integer     k, m;
    qei_integration dut_u (.clk_sys(clk_sys), .reset_n(reset_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .quad_phase_a_in(qa), .quad_phase_b_in(qb),
        .index_in(qi), .strobe_in(qs), .phase_error_out(perr),
        .cmp_sync_out(csync), .high_end_timer_err_n(tmr_n), .irq(irq));
    qei_enc_model enc_u (.clk_sys(clk_sys), .quad_a(qa), .quad_b(qb),
        .idx(qi), .stb(qs));
    always #20 clk_sys = ~clk_sys;
    // Pulse counters catch one-cycle pulses and tell one from two; the
    // cycle counter cuts a hang short.
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (tmr_n === 1'b0) tmr_lows <= tmr_lows + 1;
        if (csync[0] === 1'b1) cmp_hits <= cmp_hits + 1;
        if (cyc == 30000) begin
            err_count = err_count + 1;
            end_of_test;
        end
    end
    // One APB transfer; the request stands until pready is sampled.
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge clk_sys);
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge clk_sys);
            penable <= 1'b1;
            @(posedge clk_sys);
            // Only the bench timeout may end this wait.
            while (pready !== 1'b1) begin
                @(posedge clk_sys);
            end
            rd = prdata;
            rerr = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task chk(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_checks = n_checks + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("[ERR] %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task end_of_test;
        begin
            if (err_count == 0 && n_checks > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    // Main sequence; the level group leaves the pins idle, later groups leave the phases where they stop.
    initial begin
        repeat (20) @(posedge clk_sys);
        reset_n <= 1'b1;
        apb(0, `QEI_ADDR_CLK_DIS, 0);
        chk("clk_dis", rd, `QEI_RST_CLK_DIS);
        apb(0, `QEI_ADDR_PATH_SEL, 0);
        chk("path_sel", rd, `QEI_RST_PATH_SEL);
        apb(0, 12'h0fc, 0);
        chk("unmapped", {31'h0, rerr}, 32'h1);
        // Filter width 8 keeps a filtered edge hidden at the first read.
        apb(1, `QEI_ADDR_CTRL, 32'h00000080);
        for (k = 0; k < 4; k = k + 1) begin
            for (m = 0; m < 3; m = m + 1) begin
                apb(1, `QEI_ADDR_PATH_SEL,
                    (m == 2 ? 32'h0 : 32'h1 << m) << (8 * k));
                enc_u.lvl(k, 1'b1);
                apb(0, `QEI_ADDR_PIN_LEVEL, 0);
                chk("fast", rd, m == 1 ? 0 : 32'h11 << k);
                repeat (12) @(posedge clk_sys);
                apb(0, `QEI_ADDR_PIN_LEVEL, 0);
                chk("slow", rd, 32'h11 << k);
                enc_u.lvl(k, 1'b0);
                repeat (12) @(posedge clk_sys);
            end
        end
        apb(1, `QEI_ADDR_PATH_SEL, 32'h01010101);
        apb(1, `QEI_ADDR_CTRL, 0);
        enc_u.lvl(2, 1'b1);
        enc_u.lvl(2, 1'b0);
        for (k = 0; k < 3; k = k + 1) enc_u.step(0, 1);
        enc_u.step(0, 0);
        apb(0, `QEI_ADDR_POS0, 0);
        chk("pos0", rd, 32'h2);
        apb(0, `QEI_ADDR_POS1, 0);
        chk("pos1", rd, 32'h0);
        // Pins return to the frozen state so release causes no step.
        apb(1, `QEI_ADDR_CLK_DIS, 32'h200);
        enc_u.step(0, 1);
        apb(0, `QEI_ADDR_POS0, 0);
        chk("frozen", rd, 32'h2);
        enc_u.step(0, 0);
        apb(1, `QEI_ADDR_CLK_DIS, 0);
        apb(1, `QEI_ADDR_CMP0, 32'h3);
        // The level tests passed through zero and left compare events.
        apb(1, `QEI_ADDR_INT_STAT, 32'hf);
        apb(1, `QEI_ADDR_INT_MASK, 32'hf);
        base = cmp_hits;
        enc_u.step(0, 1);
        // The pulse is counted one edge after it stands; let it land.
        repeat (2) @(posedge clk_sys);
        chk("cmp_sync", cmp_hits - base, 32'h1);
        apb(0, `QEI_ADDR_INT_STAT, 0);
        chk("stat_cmp", rd, 32'h4);
        chk("irq_on", {31'h0, irq}, 32'h1);
        apb(1, `QEI_ADDR_INT_STAT, 32'hf);
        apb(0, `QEI_ADDR_INT_STAT, 0);
        chk("stat_clr", rd, 32'h0);
        chk("irq_off", {31'h0, irq}, 32'h0);
        base = tmr_lows;
        enc_u.bad(0);
        repeat (2) @(posedge clk_sys);
        chk("tmr_sel0", tmr_lows - base, 32'h1);
        apb(1, `QEI_ADDR_CTRL, 32'h1);
        apb(1, `QEI_ADDR_INT_STAT, 32'hf);
        base = tmr_lows;
        enc_u.bad(0);
        repeat (2) @(posedge clk_sys);
        chk("tmr_other", tmr_lows - base, 32'h0);
        enc_u.bad(1);
        repeat (2) @(posedge clk_sys);
        chk("tmr_sel1", tmr_lows - base, 32'h1);
        apb(1, `QEI_ADDR_INT_MASK, 32'h0);
        apb(0, `QEI_ADDR_INT_STAT, 0);
        chk("stat_err", rd, 32'h3);
        chk("irq_mask", {31'h0, irq}, 32'h0);
        end_of_test;
    end
endmodule
bind qei_integration qei_integration_chk chk_u (.clk_sys(clk_sys),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .quad_phase_a_in(quad_phase_a_in),
    .quad_phase_b_in(quad_phase_b_in), .index_in(index_in),
    .strobe_in(strobe_in), .phase_error_out(phase_error_out),
    .cmp_sync_out(cmp_sync_out), .irq(irq),
    .high_end_timer_err_n(high_end_timer_err_n));
